// [inc/t3cf_pkg.sv]
// Shared constants and types for the timer 3 control and flag block.
`default_nettype none
package t3cf_pkg;

    // Special-function register addresses.
    localparam logic [7:0] ADDR_CTRL   = 8'h91;
    localparam logic [7:0] ADDR_RL_LO  = 8'h92;
    localparam logic [7:0] ADDR_RL_HI  = 8'h93;
    localparam logic [7:0] ADDR_CNT_LO = 8'h94;
    localparam logic [7:0] ADDR_CNT_HI = 8'h95;

    // Reset values.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // Byte roll-over value and the external oscillator capture divider.
    localparam logic [7:0] BYTE_MAX    = 8'hff;
    localparam int         EXT_CAP_DIV = 8;
    localparam logic [2:0] EXT_CNT_LAST = 3'(EXT_CAP_DIV - 1);

    // Control register layout, bit 7 first.
    typedef struct packed {
        logic       high_byte_overflow_flag;
        logic       low_byte_overflow_flag;
        logic       low_byte_irq_enable;
        logic       capture_mode_enable;
        logic       split_mode_enable;
        logic       upper_timer_run_control;
        logic [1:0] external_clock_select;
    } t3cf_ctrl_t;

    // Special-function register access from the CPU.
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } t3cf_sfr_req_t;

    // State of the synchroniser and edge detector.
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } t3cf_sync_t;

    // All state of the main block.
    typedef struct packed {
        t3cf_ctrl_t ctrl;
        logic [7:0] cnt_lo;
        logic [7:0] cnt_hi;
        logic [7:0] rl_lo;
        logic [7:0] rl_hi;
        logic [2:0] ext_cnt;
        logic [7:0] rdata;
    } t3cf_state_t;

endpackage
`default_nettype wire

// [src/t3cf_sync_rise.sv]
// Two-flop synchroniser with a rising-edge pulse for an oscillator input.
`timescale 1ns/1ps
`default_nettype none
module t3cf_sync_rise (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_sys_rst,
    // Asynchronous level in, synchronous pulse out
    input  wire logic i_async,
    output logic      o_rise
);
    import t3cf_pkg::*;

    t3cf_sync_t q;
    t3cf_sync_t d;

    always_comb begin
        d.s1 = i_async;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Only the second and third stages feed the edge detector.
    assign o_rise = q.s2 & ~q.s3;

endmodule
`default_nettype wire

// [src/t3cf_timer3.sv]
// Timer 3 counter, reload, control register, flags and interrupt request.
// Operation
// - The high-byte overflow flag sets when the upper byte rolls from ff.
// - In 16-bit mode the high flag sets when the counter wraps from ffff.
// - With the timer interrupt enabled, a set high flag requests the CPU.
// - Both flags stay set until software clears them, not on interrupt.
// - The low-byte flag sets on every low byte roll-over in either mode.
// - Low-byte overflows interrupt only with the low enable and timer interrupt on.
// - The capture-enable bit turns oscillator capture mode on and off.
// - Split mode runs two 8-bit reloading timers, else one 16-bit timer.
// - A 16-bit wrap loads the two reload bytes into the counter; in capture mode it wraps to 0000.
// - In split mode the low timer always runs; run gates the high one.
// - Capture fires on each clock rise or every 8 oscillator cycles.
// - A capture copies the counter to the reload bytes and sets high flag.
`timescale 1ns/1ps
`default_nettype none
module t3cf_timer3 (
    // Clock and reset
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_sys_rst,
    // Special-function register access
    input  wire t3cf_pkg::t3cf_sfr_req_t  i_sfr_req,
    output logic [7:0]                    o_sfr_rdata,
    // Count enables from the clock select logic
    input  wire logic                     i_tick_low,
    input  wire logic                     i_tick_high,
    // Capture sources, asynchronous
    input  wire logic                     i_rtc_osc,
    input  wire logic                     i_ext_osc,
    // Interrupt controller
    input  wire logic                     i_irq_enable,
    output logic                          o_irq,
    // Mode visible to the clock select logic
    output logic [1:0]                    o_external_clock_select
);
    import t3cf_pkg::*;

    t3cf_state_t q;
    t3cf_state_t d;
    logic        rtc_rise;
    logic        ext_rise;
    logic        lo_ovf;
    logic        hi_ovf;
    logic        cap_evt;
    logic        wr_ctrl;

    function automatic logic wr_hit(input t3cf_sfr_req_t r,
                                    input logic [7:0] a);
        wr_hit = r.wr & (r.addr == a);
    endfunction

    t3cf_sync_rise u_rtc_sync (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_rtc_osc),
        .o_rise    (rtc_rise)
    );

    t3cf_sync_rise u_ext_sync (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_ext_osc),
        .o_rise    (ext_rise)
    );

    always_comb begin
        d       = q;
        lo_ovf  = 1'b0;
        hi_ovf  = 1'b0;
        wr_ctrl = wr_hit(i_sfr_req, ADDR_CTRL);
        if (ext_rise) begin
            d.ext_cnt = q.ext_cnt + 3'h1;
        end
        // Select bit 1 picks the divided oscillator over the clock edge.
        cap_evt = q.ctrl.capture_mode_enable &
                  (q.ctrl.external_clock_select[1] ?
                   (ext_rise & (q.ext_cnt == EXT_CNT_LAST)) : rtc_rise);
        if (!q.ctrl.split_mode_enable) begin
            if (q.ctrl.upper_timer_run_control & i_tick_low) begin
                lo_ovf = (q.cnt_lo == BYTE_MAX);
                hi_ovf = lo_ovf & (q.cnt_hi == BYTE_MAX);
                {d.cnt_hi, d.cnt_lo} = {q.cnt_hi, q.cnt_lo} + 16'h0001;
                // Capture mode keeps the reload bytes for the captured value.
                if (hi_ovf & !q.ctrl.capture_mode_enable) begin
                    {d.cnt_hi, d.cnt_lo} = {q.rl_hi, q.rl_lo};
                end
            end
        end else begin
            if (i_tick_low) begin
                lo_ovf   = (q.cnt_lo == BYTE_MAX);
                d.cnt_lo = lo_ovf ? q.rl_lo : q.cnt_lo + 8'h01;
            end
            if (q.ctrl.upper_timer_run_control & i_tick_high) begin
                hi_ovf   = (q.cnt_hi == BYTE_MAX);
                d.cnt_hi = hi_ovf ? q.rl_hi : q.cnt_hi + 8'h01;
            end
        end
        // Software writes to the counter take precedence over counting.
        if (wr_hit(i_sfr_req, ADDR_CNT_LO)) begin
            d.cnt_lo = i_sfr_req.wdata;
        end
        if (wr_hit(i_sfr_req, ADDR_CNT_HI)) begin
            d.cnt_hi = i_sfr_req.wdata;
        end
        // A capture overrides a reload write in the same cycle.
        if (cap_evt) begin
            {d.rl_hi, d.rl_lo} = {q.cnt_hi, q.cnt_lo};
        end else begin
            if (wr_hit(i_sfr_req, ADDR_RL_LO)) begin
                d.rl_lo = i_sfr_req.wdata;
            end
            if (wr_hit(i_sfr_req, ADDR_RL_HI)) begin
                d.rl_hi = i_sfr_req.wdata;
            end
        end
        if (wr_ctrl) begin
            d.ctrl = t3cf_ctrl_t'(i_sfr_req.wdata);
        end
        // Hardware sets are ORed in last so a clear cannot lose an event.
        d.ctrl.high_byte_overflow_flag = d.ctrl.high_byte_overflow_flag |
                                         hi_ovf | cap_evt;
        d.ctrl.low_byte_overflow_flag  = d.ctrl.low_byte_overflow_flag |
                                         lo_ovf;
        case (i_sfr_req.addr)
            ADDR_CTRL:   d.rdata = q.ctrl;
            ADDR_RL_LO:  d.rdata = q.rl_lo;
            ADDR_RL_HI:  d.rdata = q.rl_hi;
            ADDR_CNT_LO: d.rdata = q.cnt_lo;
            ADDR_CNT_HI: d.rdata = q.cnt_hi;
            default:     d.rdata = BYTE_RST;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            q.ctrl    <= t3cf_ctrl_t'(CTRL_RST);
            q.cnt_lo  <= BYTE_RST;
            q.cnt_hi  <= BYTE_RST;
            q.rl_lo   <= BYTE_RST;
            q.rl_hi   <= BYTE_RST;
            q.ext_cnt <= 3'h0;
            q.rdata   <= BYTE_RST;
        end else begin
            q <= d;
        end
    end

    assign o_sfr_rdata = q.rdata;
    assign o_external_clock_select = q.ctrl.external_clock_select;
    // The request is a level; it drops when the flags or their enables clear, or when i_irq_enable falls.
    assign o_irq = i_irq_enable & (q.ctrl.high_byte_overflow_flag |
                   (q.ctrl.low_byte_irq_enable &
                    q.ctrl.low_byte_overflow_flag));

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    logic no_cnt_wr;
    assign no_cnt_wr = !wr_hit(i_sfr_req, ADDR_CNT_LO) &&
                       !wr_hit(i_sfr_req, ADDR_CNT_HI);

    a_wrap_reload: assert property (
        !q.ctrl.split_mode_enable && !q.ctrl.capture_mode_enable &&
        q.ctrl.upper_timer_run_control && i_tick_low && no_cnt_wr &&
        q.cnt_lo == 8'hff && q.cnt_hi == 8'hff && !cap_evt
        |=> {q.cnt_hi, q.cnt_lo} == $past({q.rl_hi, q.rl_lo}))
        else $error("16-bit wrap did not load the reload value");

    a_wrap_high_flag: assert property (
        $rose(q.ctrl.high_byte_overflow_flag) && !$past(cap_evt) &&
        !$past(wr_ctrl) && !$past(q.ctrl.split_mode_enable)
        |-> $past({q.cnt_hi, q.cnt_lo}) == 16'hffff)
        else $error("High flag rose without a 16-bit wrap");

    a_split_high_flag: assert property (
        q.ctrl.split_mode_enable && q.ctrl.upper_timer_run_control &&
        i_tick_high && q.cnt_hi == 8'hff
        |=> q.ctrl.high_byte_overflow_flag && q.cnt_hi == $past(q.rl_hi))
        else $error("Split high byte overflow not flagged");

    a_low_flag_set: assert property (
        lo_ovf |=> q.ctrl.low_byte_overflow_flag)
        else $error("Low byte overflow not flagged");

    a_flags_sticky: assert property (
        !wr_ctrl [*2] |-> ##1
        $stable({q.ctrl.high_byte_overflow_flag,
                 q.ctrl.low_byte_overflow_flag}) ||
        $rose(q.ctrl.high_byte_overflow_flag) ||
        $rose(q.ctrl.low_byte_overflow_flag))
        else $error("Overflow flag cleared without a write");

    a_set_wins: assert property (
        wr_ctrl && !i_sfr_req.wdata[6] && lo_ovf
        |=> q.ctrl.low_byte_overflow_flag)
        else $error("Low flag clear beat a hardware set");

    a_irq_high: assert property (
        q.ctrl.high_byte_overflow_flag && i_irq_enable |-> o_irq)
        else $error("High flag set but no interrupt request");

    a_irq_low_gate: assert property (
        !q.ctrl.high_byte_overflow_flag &&
        !(q.ctrl.low_byte_irq_enable && i_irq_enable) |-> !o_irq)
        else $error("Low overflow requested an interrupt while gated");

    a_capture_copy: assert property (
        cap_evt |=> {q.rl_hi, q.rl_lo} == $past({q.cnt_hi, q.cnt_lo}) &&
        q.ctrl.high_byte_overflow_flag)
        else $error("Capture did not copy the counter");

    a_capture_off: assert property (
        !q.ctrl.capture_mode_enable && !wr_hit(i_sfr_req, ADDR_RL_LO) &&
        !wr_hit(i_sfr_req, ADDR_RL_HI) |=> $stable({q.rl_hi, q.rl_lo}))
        else $error("Reload bytes changed with capture mode off");

    a_capture_rtc: assert property (
        q.ctrl.capture_mode_enable && !q.ctrl.external_clock_select[1] &&
        rtc_rise |=> q.ctrl.high_byte_overflow_flag &&
        {q.rl_hi, q.rl_lo} == $past({q.cnt_hi, q.cnt_lo}))
        else $error("Clock rise did not capture");

    a_split_high_halt: assert property (
        q.ctrl.split_mode_enable && !q.ctrl.upper_timer_run_control &&
        no_cnt_wr |=> q.cnt_hi == $past(q.cnt_hi))
        else $error("Upper split timer counted while stopped");

    c_wrap16:  cover property (hi_ovf && !q.ctrl.split_mode_enable);
    c_split:   cover property (lo_ovf && q.ctrl.split_mode_enable);
    c_capture: cover property (cap_evt);
    c_setwins: cover property (wr_ctrl && lo_ovf);

endmodule
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the timer 3 control and flag block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import t3cf_pkg::*;
    logic          clk, rst, tl, th, rtc, ext, en, irq;
    t3cf_sfr_req_t req;
    logic [7:0]    rdata, m, rl, rh;
    logic [1:0]    xcs;
    logic [15:0]   c;
    logic [31:0]   seed;
    int            err_count, cmp_count;

    t3cf_timer3 t3cf_timer3_inst (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_sfr_req(req),
        .o_sfr_rdata(rdata), .i_tick_low(tl), .i_tick_high(th),
        .i_rtc_osc(rtc), .i_ext_osc(ext), .i_irq_enable(en), .o_irq(irq),
        .o_external_clock_select(xcs));

    always #5 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One clock of stimulus; the model follows the same edge.
    task automatic cyc(input logic w, input logic [7:0] a,
                       input logic [7:0] d, input logic t0, input logic t1);
        logic hs, ls;
        hs = 1'b0;
        ls = 1'b0;
        req = '{wr: w, addr: a, wdata: d};
        tl = t0;
        th = t1;
        @(posedge clk);
        #1;
        if (!m[3]) begin
            if (t0 && m[2]) begin
                ls = (c[7:0] == 8'hff);
                hs = (c == 16'hffff);
                c = hs ? (m[4] ? 16'h0000 : {rh, rl}) : c + 16'h0001;
            end
        end else begin
            if (t0) begin
                ls = (c[7:0] == 8'hff);
                c[7:0] = ls ? rl : c[7:0] + 8'h01;
            end
            if (t1 && m[2]) begin
                hs = (c[15:8] == 8'hff);
                c[15:8] = hs ? rh : c[15:8] + 8'h01;
            end
        end
        if (w) begin
            case (a)
                ADDR_CTRL:   m = d;
                ADDR_RL_LO:  rl = d;
                ADDR_RL_HI:  rh = d;
                ADDR_CNT_LO: c[7:0] = d;
                ADDR_CNT_HI: c[15:8] = d;
                default:     ;
            endcase
        end
        m[7] = m[7] | hs;
        m[6] = m[6] | ls;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1'b1, a, d, 1'b0, 1'b0);
    endtask

    task automatic idle(input int n);
        repeat (n) cyc(1'b0, ADDR_CTRL, 8'h00, 1'b0, 1'b0);
    endtask

    task automatic irqchk;
        chk({7'h00, irq}, {7'h00, en & (m[7] | (m[5] & m[6]))});
    endtask

    task automatic rd_all(input string name);
        logic [7:0] exp [5];
        exp = '{m, rl, rh, c[7:0], c[15:8]};
        for (int i = 0; i < 5; i++) begin
            cyc(1'b0, ADDR_CTRL + 8'(i), 8'h00, 1'b0, 1'b0);
            chk(rdata, exp[i]);
        end
        irqchk();
        $display("Test %s done", name);
    endtask

    task automatic end_sim;
        $display("Compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // The whole run needs well under ten thousand cycles.
    initial begin
        #200000;
        err_count++;
        end_sim();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        {tl, th, rtc, ext, en} = 5'h00;
        {m, rl, rh, c} = 40'h0;
        seed = 32'h2068f75d;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        en = 1'b1;
        rd_all("reset");
        cyc(1'b0, 8'h96, 8'h00, 1'b0, 1'b0);
        chk(rdata, 8'h00);
        wr(ADDR_RL_LO, 8'h34);
        wr(ADDR_RL_HI, 8'h12);
        wr(ADDR_CNT_LO, 8'hfe);
        wr(ADDR_CNT_HI, 8'hff);
        wr(ADDR_CTRL, 8'h07);
        chk({6'h00, xcs}, 8'h03);
        cyc(1'b0, ADDR_CTRL, 8'h00, 1'b1, 1'b0);
        cyc(1'b0, ADDR_CTRL, 8'h00, 1'b1, 1'b0);
        irqchk();
        idle(6);
        rd_all("wrap");
        en = 1'b0;
        cyc(1'b0, ADDR_CTRL, 8'h00, 1'b0, 1'b0);
        irqchk();
        en = 1'b1;
        wr(ADDR_CNT_LO, 8'hff);
        wr(ADDR_CNT_HI, 8'hff);
        cyc(1'b1, ADDR_CTRL, 8'h04, 1'b1, 1'b0);
        rd_all("set wins");
        wr(ADDR_CTRL, 8'h28);
        wr(ADDR_CNT_LO, 8'hff);
        wr(ADDR_RL_LO, 8'h80);
        cyc(1'b0, ADDR_CTRL, 8'h00, 1'b1, 1'b1);
        irqchk();
        wr(ADDR_CTRL, 8'h2c);
        cyc(1'b0, ADDR_CTRL, 8'h00, 1'b0, 1'b1);
        rd_all("split");
        wr(ADDR_CTRL, 8'h0c);
        wr(ADDR_CNT_LO, 8'hff);
        cyc(1'b0, ADDR_CTRL, 8'h00, 1'b1, 1'b0);
        rd_all("low masked");
        wr(ADDR_CTRL, 8'h10);
        wr(ADDR_CNT_LO, 8'h21);
        wr(ADDR_CNT_HI, 8'h43);
        rtc = 1'b1;
        idle(6);
        {rh, rl} = c;
        m[7] = 1'b1;
        rd_all("rtc capture");
        rtc = 1'b0;
        wr(ADDR_CTRL, 8'h12);
        wr(ADDR_CNT_LO, 8'h65);
        for (int i = 0; i < 8; i++) begin
            ext = 1'b1;
            idle(3);
            ext = 1'b0;
            idle(3);
        end
        {rh, rl} = c;
        m[7] = 1'b1;
        rd_all("ext capture");
        for (int mode = 0; mode < 2; mode++) begin
            seed = lfsr(seed);
            wr(ADDR_CTRL, (mode == 1) ? 8'h2c : 8'h24);
            wr(ADDR_RL_LO, seed[7:0]);
            wr(ADDR_RL_HI, seed[15:8]);
            wr(ADDR_CNT_LO, seed[23:16]);
            wr(ADDR_CNT_HI, 8'hfe);
            for (int k = 0; k < 400; k++) begin
                seed = lfsr(seed);
                en = seed[0];
                cyc(1'b0, ADDR_CTRL, 8'h00, seed[1], seed[2]);
                irqchk();
            end
            rd_all("random");
        end
        // A mid-run reset must clear every register and drop the request.
        rst = 1'b1;
        idle(2);
        rst = 1'b0;
        {m, rl, rh, c} = 40'h0;
        rd_all("mid reset");
        end_sim();
    end
endmodule
`default_nettype wire
